// [mft_defs.svh]
`ifndef MFT_DEFS_SVH
`define MFT_DEFS_SVH

// register indices; byte address is four times the index
`define MFT_IDX_CAP_LO 5'h00
`define MFT_IDX_CAP_HI 5'h01
`define MFT_IDX_CMP2_LO_RD 5'h02
`define MFT_IDX_CMP2_HI_RD 5'h03
`define MFT_IDX_CMP1_LO_RD 5'h04
`define MFT_IDX_CMP1_HI_RD 5'h05
`define MFT_IDX_CTRL_B_RD 5'h06
`define MFT_IDX_CTRL_A_RD 5'h07
`define MFT_IDX_CLEAR 5'h10
`define MFT_IDX_CMP2_LO_WR 5'h12
`define MFT_IDX_CMP2_HI_WR 5'h13
`define MFT_IDX_CMP1_LO_WR 5'h14
`define MFT_IDX_CMP1_HI_WR 5'h15
`define MFT_IDX_CTRL_B_WR 5'h16
`define MFT_IDX_CTRL_A_WR 5'h17

// control a bits
`define MFT_A_OVIE 0
`define MFT_A_OVF 1
`define MFT_A_CMIE 2
`define MFT_A_CMF1 3
`define MFT_A_CMF2 4
`define MFT_A_CPIE 5
`define MFT_A_CPF1 6
`define MFT_A_CPF2 7

// control b fields
`define MFT_B_MODE_LSB 0
`define MFT_B_PS_LSB 2
`define MFT_B_EVT_EDGE 5
`define MFT_B_CAP_EDGE 6

`define MFT_CNT_ZERO 16'h0000
`define MFT_CNT_MAX 16'hffff
`define MFT_BYTE_ZERO 8'h00
`define MFT_WORD_ZERO 32'h0000_0000

`endif

// [mft_pins.sv]
`timescale 1ns/1ps
`default_nettype none
module mft_pins (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // toggle requests
    input wire logic tog_a,
    input wire logic tog_b,
    input wire logic tog_e,
    // pins
    output logic capture_in_a,
    output logic capture_in_b,
    output logic event_clock_in
);
    // pins idle low; each request flips one pin so rises and falls alternate
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            capture_in_a <= 1'b0;
            capture_in_b <= 1'b0;
            event_clock_in <= 1'b0;
        end
        else
        begin
            capture_in_a <= capture_in_a ^ tog_a;
            capture_in_b <= capture_in_b ^ tog_b;
            event_clock_in <= event_clock_in ^ tog_e;
        end
    end
endmodule
`default_nettype wire

// [mft_pkg.sv]
package mft_pkg;

    typedef enum logic [1:0] {
        MFT_SOFT = 2'b00,
        MFT_PWM = 2'b01,
        MFT_CAPCMP = 2'b10,
        MFT_EVENT = 2'b11
    } mft_mode_t;

endpackage

// [mft_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mft_defs.svh"

module mft_timer #(
    parameter int PS_BITS = 3
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer pins
    input wire logic capture_in_a,
    input wire logic capture_in_b,
    input wire logic event_clock_in,
    output logic wave_out,
    output logic wave_oe,
    // port bit the wave pin shares
    input wire logic port_data_latch,
    input wire logic port_dir_out,
    // interrupt request
    output logic timer_irq
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [15:0] count;
    logic [15:0] capture_value;
    logic [15:0] first_compare_value;
    logic [15:0] second_compare_capture_value;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic second_phase;
    logic pulse;
    logic [(1 << PS_BITS) - 2:0] presc;
    logic evt_prev;
    logic cap_a_prev;
    logic cap_b_prev;

    mft_pkg::mft_mode_t mode;
    logic [PS_BITS-1:0] ps_sel;
    logic evt_rise_sel;
    logic cap_rise_sel;

    assign mode = mft_pkg::mft_mode_t'(ctrl_b[`MFT_B_MODE_LSB +: 2]);
    assign ps_sel = ctrl_b[`MFT_B_PS_LSB +: PS_BITS];
    assign evt_rise_sel = ctrl_b[`MFT_B_EVT_EDGE];
    assign cap_rise_sel = ctrl_b[`MFT_B_CAP_EDGE];

    ////////////////////////////////////////////////////////////////////////
    // apb decode; one wait-free access phase
    logic acc;
    logic wr;
    logic [4:0] idx;
    logic mapped;

    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign idx = paddr[6:2];
    assign pready = 1'b1;

    always_comb
    begin
        case (idx)
            `MFT_IDX_CAP_LO, `MFT_IDX_CAP_HI, `MFT_IDX_CMP2_LO_RD, `MFT_IDX_CMP2_HI_RD,
            `MFT_IDX_CMP1_LO_RD, `MFT_IDX_CMP1_HI_RD, `MFT_IDX_CTRL_B_RD, `MFT_IDX_CTRL_A_RD:
                mapped = !pwrite;
            `MFT_IDX_CLEAR, `MFT_IDX_CMP2_LO_WR, `MFT_IDX_CMP2_HI_WR, `MFT_IDX_CMP1_LO_WR,
            `MFT_IDX_CMP1_HI_WR, `MFT_IDX_CTRL_B_WR, `MFT_IDX_CTRL_A_WR:
                mapped = pwrite;
            default:
                mapped = 1'b0;
        endcase
        if (paddr[31:7] != 25'h0000000 || paddr[1:0] != 2'h0)
        begin
            mapped = 1'b0;
        end
    end

    assign pslverr = acc & !mapped;

    logic wr_ok;
    assign wr_ok = wr & mapped;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= `MFT_WORD_ZERO;
        end
        else if (psel && !penable && !pwrite)
        begin
            case (idx)
                `MFT_IDX_CAP_LO: prdata <= {24'h000000, capture_value[7:0]};
                `MFT_IDX_CAP_HI: prdata <= {24'h000000, capture_value[15:8]};
                `MFT_IDX_CMP2_LO_RD: prdata <= {24'h000000, second_compare_capture_value[7:0]};
                `MFT_IDX_CMP2_HI_RD: prdata <= {24'h000000, second_compare_capture_value[15:8]};
                `MFT_IDX_CMP1_LO_RD: prdata <= {24'h000000, first_compare_value[7:0]};
                `MFT_IDX_CMP1_HI_RD: prdata <= {24'h000000, first_compare_value[15:8]};
                `MFT_IDX_CTRL_B_RD: prdata <= {25'h0000000, ctrl_b[6:0]};
                `MFT_IDX_CTRL_A_RD: prdata <= {24'h000000, ctrl_a};
                default: prdata <= `MFT_WORD_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer clock: prescaler tick or selected event edge
    logic [(1 << PS_BITS) - 2:0] ps_mask;
    logic tick;
    logic evt_edge;
    logic cap_a_edge;
    logic cap_b_edge;

    for (genvar gi = 0; gi < (1 << PS_BITS) - 1; gi++)
    begin : g_ps_mask
        assign ps_mask[gi] = (ps_sel > gi);
    end
    assign evt_edge = evt_rise_sel ? (event_clock_in & !evt_prev) : (!event_clock_in & evt_prev);
    assign cap_a_edge = cap_rise_sel ? (capture_in_a & !cap_a_prev) : (!capture_in_a & cap_a_prev);
    assign cap_b_edge = cap_rise_sel ? (capture_in_b & !cap_b_prev) : (!capture_in_b & cap_b_prev);
    // prescaler runs free, so a new divide factor takes effect within one period
    assign tick = (mode == mft_pkg::MFT_EVENT) ? evt_edge : ((presc & ps_mask) == ps_mask);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            presc <= '0;
        end
        else
        begin
            presc <= presc + 1'b1;
        end
    end

    // previous levels start at the idle low of the pins, so reset gives no false edge
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_prev <= 1'b0;
            cap_a_prev <= 1'b0;
            cap_b_prev <= 1'b0;
        end
        else
        begin
            evt_prev <= event_clock_in;
            cap_a_prev <= capture_in_a;
            cap_b_prev <= capture_in_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter and match logic
    logic capcmp;
    logic [15:0] target;
    logic hit;
    logic clear_cmd;
    logic [15:0] count_inc;

    assign capcmp = (mode == mft_pkg::MFT_CAPCMP);
    assign target = (second_phase && !capcmp) ? second_compare_capture_value : first_compare_value;
    assign count_inc = count + 1'b1;
    // modes other than capture/compare restart on the tick that would reach the target, so a phase lasts target ticks
    assign hit = tick && (capcmp ? (count == target) : (count_inc == target));
    assign clear_cmd = wr_ok && idx == `MFT_IDX_CLEAR;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= `MFT_CNT_ZERO;
            second_phase <= 1'b0;
            pulse <= 1'b0;
        end
        else if (clear_cmd)
        begin
            count <= `MFT_CNT_ZERO;
            second_phase <= 1'b0;
            pulse <= 1'b0;
        end
        else if (tick)
        begin
            if (capcmp)
            begin
                count <= count_inc;
                if (hit)
                begin
                    pulse <= !pulse;
                end
            end
            else if (hit)
            begin
                count <= `MFT_CNT_ZERO;
                second_phase <= !second_phase;
                pulse <= !second_phase;
            end
            else
            begin
                // a target below the count is reached only after the wrap
                count <= count_inc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare and capture registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_compare_value <= `MFT_CNT_ZERO;
        end
        else if (wr_ok && idx == `MFT_IDX_CMP1_LO_WR)
        begin
            first_compare_value[7:0] <= pwdata[7:0];
        end
        else if (wr_ok && idx == `MFT_IDX_CMP1_HI_WR)
        begin
            first_compare_value[15:8] <= pwdata[7:0];
        end
    end

    // capture wins over a software write in the same cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            second_compare_capture_value <= `MFT_CNT_ZERO;
        end
        else if (capcmp && cap_b_edge)
        begin
            second_compare_capture_value <= count;
        end
        else if (wr_ok && idx == `MFT_IDX_CMP2_LO_WR)
        begin
            second_compare_capture_value[7:0] <= pwdata[7:0];
        end
        else if (wr_ok && idx == `MFT_IDX_CMP2_HI_WR)
        begin
            second_compare_capture_value[15:8] <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            capture_value <= `MFT_CNT_ZERO;
        end
        else if (capcmp && cap_a_edge)
        begin
            capture_value <= count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers and pending flags
    logic [7:0] set_a;

    always_comb
    begin
        set_a = `MFT_BYTE_ZERO;
        set_a[`MFT_A_OVF] = tick && !clear_cmd && count == `MFT_CNT_MAX && (capcmp || !hit);
        set_a[`MFT_A_CMF1] = hit && !clear_cmd && (capcmp || !second_phase);
        set_a[`MFT_A_CMF2] = hit && !clear_cmd && !capcmp && second_phase;
        set_a[`MFT_A_CPF1] = capcmp && cap_a_edge;
        set_a[`MFT_A_CPF2] = capcmp && cap_b_edge;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_b <= `MFT_BYTE_ZERO;
        end
        else if (wr_ok && idx == `MFT_IDX_CTRL_B_WR)
        begin
            ctrl_b <= {1'b0, pwdata[6:0]};
        end
    end

    // flags: writing 0 clears, writing 1 keeps; a new event beats the clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_a <= `MFT_BYTE_ZERO;
        end
        else if (wr_ok && idx == `MFT_IDX_CTRL_A_WR)
        begin
            ctrl_a <= (pwdata[7:0] & ctrl_a & 8'hda) | (pwdata[7:0] & 8'h25) | set_a;
        end
        else
        begin
            ctrl_a <= ctrl_a | set_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin and interrupt outputs
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wave_out <= 1'b0;
        end
        else
        begin
            // software timer and event modes leave the pin to the port latch
            wave_out <= (mode == mft_pkg::MFT_PWM || capcmp) ? pulse : port_data_latch;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wave_oe <= 1'b0;
        end
        else
        begin
            wave_oe <= port_dir_out;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_irq <= 1'b0;
        end
        else
        begin
            timer_irq <= (ctrl_a[`MFT_A_OVF] & ctrl_a[`MFT_A_OVIE])
                | ((ctrl_a[`MFT_A_CMF1] | ctrl_a[`MFT_A_CMF2]) & ctrl_a[`MFT_A_CMIE])
                | ((ctrl_a[`MFT_A_CPF1] | ctrl_a[`MFT_A_CPF2]) & ctrl_a[`MFT_A_CPIE]);
        end
    end

endmodule

`default_nettype wire

// [mft_timer_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module mft_timer_checker #(
    parameter int PS_BITS = 3
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pin and irq
    input wire logic port_dir_out,
    input wire logic wave_oe,
    input wire logic timer_irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_dir_held;
        port_dir_out [*2];
    endsequence
    ////////////////////////////////////////
    a_ready_const: assert property (pready) else $error("pready low");
    a_err_in_acc: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    a_err_far: assert property (s_acc ##0 paddr[31:7] != 25'h0 |-> pslverr) else $error("far address taken");
    a_cap_ro: assert property (s_acc ##0 pwrite && paddr == 32'h0 |-> pslverr) else $error("capture written");
    a_clear_ok: assert property (s_acc ##0 pwrite && paddr == 32'h40 |-> !pslverr) else $error("clear refused");
    a_oe_out: assert property (s_dir_held |-> wave_oe) else $error("pin not driven");
    a_oe_in: assert property (!port_dir_out [*2] |-> !wave_oe) else $error("input pin driven");
    a_rd_upper: assert property (prdata[31:8] == 24'h0) else $error("prdata upper bits set");
    a_irq_rst: assert property ($rose(rst_n) |-> !timer_irq) else $error("irq after reset");
endmodule
bind mft_timer mft_timer_checker #(.PS_BITS(PS_BITS)) mft_timer_checker_i (.clock, .rst_n, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .port_dir_out, .wave_oe, .timer_irq);
`default_nettype wire

// [test_multifunction_timer_modes.sv]
`timescale 1ns/1ps
`default_nettype none
module test_multifunction_timer_modes;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic port_data_latch = 1'b1;
    logic port_dir_out = 1'b0;
    logic tog_a = 1'b0;
    logic tog_b = 1'b0;
    logic tog_e = 1'b0;
    logic [31:0] prdata, rd, err;
    logic pready, pslverr, capture_in_a, capture_in_b, event_clock_in, wave_out, wave_oe, timer_irq;
    int n_mismatch = 0;
    int checks = 0;
    always #10 clock = ~clock;
    mft_timer mft_timer_i (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .capture_in_a, .capture_in_b, .event_clock_in, .wave_out, .wave_oe, .port_data_latch,
        .port_dir_out, .timer_irq);
    mft_pins mft_pins_i (.clock, .rst_n, .tog_a, .tog_b, .tog_e, .capture_in_a, .capture_in_b, .event_clock_in);
    ////////////////////////////////////////
    task results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task timeout();
        n_mismatch++;
        results();
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, then one idle edge so the next setup never lands in the same step
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        for (i = 0; pready !== 1'b1 && i < 50; i++)
            @(posedge clock);
        if (i == 50)
            timeout();
        rd = prdata;
        err = 32'(pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task wave_run(input logic lvl, output int n);
        for (n = 0; wave_out === lvl && n < 300; n++)
            @(posedge clock);
        if (n == 300)
            timeout();
    endtask
    // mode first and flags last, so no event of the previous mode survives the setup
    task setup(input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] b);
        xfer(1'b1, 32'h58, {24'h0, b});
        xfer(1'b1, 32'h50, {24'h0, r1});
        xfer(1'b1, 32'h48, {24'h0, r2});
        xfer(1'b1, 32'h40, 32'h0);
        chk(err, 32'h0);
        xfer(1'b1, 32'h5c, 32'h0);
    endtask
    ////////////////////////////////////////
    task t_reset();
        xfer(1'b0, 32'h1c, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 32'h100, 32'h0);
        chk(err, 32'h1);
        xfer(1'b1, 32'h0, 32'h55);
        chk(err, 32'h1);
        $display("reset test done");
    endtask
    task t_pwm(input logic [2:0] ps);
        int lo, hi;
        port_dir_out <= 1'b1;
        setup(8'h05, 8'h02, {3'b000, ps, 2'b01});
        wave_run(1'b0, lo);
        wave_run(1'b1, hi);
        wave_run(1'b0, lo);
        chk(32'(lo), 32'(5 << ps));
        chk(32'(hi), 32'(2 << ps));
        chk(32'(wave_oe), 32'h1);
        xfer(1'b0, 32'h1c, 32'h0);
        chk(rd & 32'h18, 32'h18);
        $display("pwm test done");
    endtask
    task t_soft();
        int bad;
        setup(8'h03, 8'h03, 8'h00);
        bad = 0;
        // latch held high, so any timer drive on the pin shows as a low
        repeat (40)
        begin
            @(posedge clock);
            bad += (wave_out !== 1'b1);
        end
        chk(32'(bad), 32'h0);
        xfer(1'b0, 32'h1c, 32'h0);
        chk(rd & 32'h18, 32'h18);
        $display("soft test done");
    endtask
    task t_event();
        setup(8'h03, 8'h03, 8'h23);
        tog_e <= 1'b1;
        repeat (4) @(posedge clock);
        tog_e <= 1'b0;
        xfer(1'b0, 32'h1c, 32'h0);
        chk(rd & 32'h08, 32'h0);
        tog_e <= 1'b1;
        repeat (6) @(posedge clock);
        tog_e <= 1'b0;
        xfer(1'b0, 32'h1c, 32'h0);
        chk(rd & 32'h08, 32'h08);
        $display("event test done");
    endtask
    task t_capture();
        logic [31:0] a;
        setup(8'hf0, 8'h00, 8'h42);
        tog_a <= 1'b1;
        @(posedge clock);
        tog_a <= 1'b0;
        repeat (9) @(posedge clock);
        tog_b <= 1'b1;
        @(posedge clock);
        tog_b <= 1'b0;
        repeat (3) @(posedge clock);
        xfer(1'b0, 32'h0, 32'h0);
        a = rd;
        xfer(1'b0, 32'h08, 32'h0);
        chk((rd - a) & 32'hff, 32'h0a);
        xfer(1'b0, 32'h1c, 32'h0);
        chk(rd & 32'hc0, 32'hc0);
        xfer(1'b1, 32'h5c, 32'he0);
        repeat (2) @(posedge clock);
        chk(32'(timer_irq), 32'h1);
        xfer(1'b1, 32'h5c, 32'h20);
        repeat (2) @(posedge clock);
        chk(32'(timer_irq), 32'h0);
        // capture a falls back low; the rising-edge selection must ignore it
        tog_a <= 1'b1;
        @(posedge clock);
        tog_a <= 1'b0;
        repeat (3) @(posedge clock);
        xfer(1'b0, 32'h1c, 32'h0);
        chk(rd & 32'h40, 32'h0);
        $display("capture test done");
    endtask
    // free count passes the first compare and must still reach the wrap
    task t_over();
        int i;
        xfer(1'b1, 32'h5c, 32'h01);
        for (i = 0; timer_irq !== 1'b1 && i < 70000; i++)
            @(posedge clock);
        if (i == 70000)
            timeout();
        xfer(1'b0, 32'h1c, 32'h0);
        chk(rd & 32'h02, 32'h02);
        // exactly one pass of the first compare since the clear: flag set, pin toggled once
        chk(rd & 32'h08, 32'h08);
        chk(32'(wave_out), 32'h1);
        $display("overflow test done");
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_pwm(3'd0);
        t_pwm(3'd1);
        t_soft();
        t_event();
        t_capture();
        t_over();
        results();
    end
endmodule
`default_nettype wire
